// File: core/sfp_host.sv
// Host end: makes the link clock, frames bytes, pauses on stalls.
// Assumes user streams on clock_i and the device across the link.
`timescale 1ns/1ps
module sfp_host
  import sfp_pkg::*;
#(
  parameter int HALF  = sfp_pkg::HALF_CYC,  // Cycles per half period
  parameter bit MODE3 = 1'b0                // Idle clock high if set
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  // Link pins
  sfp_if.host                    link,
  // Write-protect level to drive, active low
  input  wire logic              wprot_n_i,
  // Bytes to send
  input  wire logic [7:0]        tx_data_i,
  input  wire logic              tx_valid_i,
  input  wire logic              tx_last_i,
  output logic                   tx_ready_o,
  // Bytes received
  output logic [7:0]             rx_data_o,
  output logic                   rx_valid_o,
  input  wire logic              rx_ready_i,
  // Frame in progress
  output logic                   busy_o
);
  import sfp_pkg::*;
  localparam int CW = $clog2(HALF + 1);

  // Whole sequencer state
  typedef struct packed {
    sfp_state_t    st;       // Sequencer state
    logic [CW-1:0] cnt;      // Half period counter
    logic [2:0]    bits;     // Bit in the byte
    logic [7:0]    tx;       // Outgoing shift
    logic [7:0]    rx;       // Incoming shift
    logic          last;     // Close frame after byte
    logic          rdy;      // Ready for next byte
    logic          push;     // Byte into buffer
    logic          sclk;     // Link clock level
    logic          sel_n;    // Select level
    logic          mosi;     // Data out level
    logic          pause_n;  // Pause level
    logic          wp_n;     // Protect pin level
    logic          ms1;      // Miso first stage
    logic          ms2;      // Miso second stage
  } sfp_host_t;

  sfp_host_t r;
  sfp_host_t next_r;
  logic      room;  // Buffer can take a byte

  // Stall by the reader fills this; a full buffer pauses the link
  sfp_buf #(.W(8), .DEPTH(RX_DEPTH)) u_rx (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .in_data_i   (r.rx),
    .in_valid_i  (r.push),
    .in_ready_o  (room),
    .out_data_o  (rx_data_o),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i)
  );

  wire logic half = (r.cnt == CW'(HALF - 1));
  wire logic take = r.rdy & tx_valid_i;

  // Sequencer
  always_comb begin
    next_r      = r;
    next_r.push = 1'b0;
    next_r.ms1  = link.miso_line;
    next_r.ms2  = r.ms1;
    next_r.wp_n = wprot_n_i;
    next_r.cnt  = half ? r.cnt : r.cnt + CW'(1);
    case (r.st)
      SFP_IDLE: begin
        if (take) begin
          next_r.tx    = tx_data_i;
          next_r.mosi  = tx_data_i[7];
          next_r.last  = tx_last_i;
          next_r.bits  = '0;
          next_r.sel_n = 1'b0;
          next_r.cnt   = '0;
          next_r.st    = SFP_START;
        end
      end
      SFP_START: begin
        // mode 3 starts high, drops here
        if (half) begin
          next_r.sclk = 1'b0;
          next_r.cnt  = '0;
          next_r.st   = SFP_LOW;
        end
      end
      SFP_LOW: begin
        // Rising edge: device takes mosi
        if (half) begin
          next_r.sclk = 1'b1;
          next_r.cnt  = '0;
          next_r.st   = SFP_HIGH;
        end
      end
      SFP_HIGH: begin
        if (half) begin
          next_r.cnt = '0;
          // first bit in is the top bit
          next_r.rx  = {r.rx[6:0], r.ms2};
          if (r.bits == 3'd7) begin
            next_r.push = 1'b1;
            next_r.sclk = r.last ? MODE3 : 1'b0;
            next_r.st   = r.last ? SFP_STOP : SFP_NEXT;
          end else begin
            next_r.bits = r.bits + 3'd1;
            next_r.tx   = {r.tx[6:0], 1'b0};
            next_r.mosi = r.tx[6];
            next_r.sclk = 1'b0;
            next_r.st   = SFP_LOW;
          end
        end
      end
      SFP_NEXT: begin
        if (take) begin
          next_r.pause_n = 1'b1;
          next_r.tx      = tx_data_i;
          next_r.mosi    = tx_data_i[7];
          next_r.last    = tx_last_i;
          next_r.bits    = '0;
          next_r.cnt     = '0;
          next_r.st      = SFP_LOW;
        end else begin
          // pause only with select low, clock low
          next_r.pause_n = 1'b0;
        end
      end
      SFP_STOP: begin
        // select rises only after the last bit
        if (half) begin
          next_r.sel_n = 1'b1;
          next_r.cnt   = '0;
          next_r.st    = SFP_IDLE;
        end
      end
      default: begin
        next_r.st = SFP_IDLE;
      end
    endcase
    // No offer while a pushed byte is still landing in the buffer
    next_r.rdy = room & ~r.push & ~next_r.push &
                 (next_r.st == SFP_NEXT ||
                  (next_r.st == SFP_IDLE && r.st == SFP_IDLE && half));
  end

  // Register the state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r         <= '0;
      r.st      <= SFP_IDLE;
      r.sclk    <= MODE3;
      r.sel_n   <= 1'b1;
      r.pause_n <= 1'b1;
      r.wp_n    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Pins and status straight from flops
  assign link.sclk    = r.sclk;
  assign link.sel_n   = r.sel_n;
  assign link.mosi    = r.mosi;
  assign link.pause_n = r.pause_n;
  assign link.wprot_n = r.wp_n;
  assign tx_ready_o   = r.rdy;
  assign busy_o       = ~r.sel_n;
endmodule : sfp_host

// File: core/sfp_pkg.sv
// Shared constants and types for the serial flash port (both ends).
// Assumes the host runs at 40 MHz and the device on the link clock.
package sfp_pkg;
  // Host system clock and the fastest link clock allowed
  localparam int CLK_HZ      = 40_000_000;
  localparam int SCK_MAX_HZ  = 20_000_000;
  // Half period in host cycles; the miso synchroniser needs two
  localparam int HALF_RAW    = (CLK_HZ + 2 * SCK_MAX_HZ - 1)
                               / (2 * SCK_MAX_HZ);
  localparam int HALF_CYC    = (HALF_RAW < 2) ? 2 : HALF_RAW;
  // Byte framing
  localparam int BYTE_W      = 8;
  localparam int ADDR_W      = 24;
  localparam int ADDR_BYTES  = 3;
  // Array layout: erase sectors overlaid by larger blocks
  localparam int SECTOR_BYTES = 4096;
  localparam int BLOCK_BYTES  = 32768;
  localparam int SECTOR_LSB   = $clog2(SECTOR_BYTES);
  localparam int BLOCK_LSB    = $clog2(BLOCK_BYTES);
  // Opcode that writes the status register
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  // Status field positions
  localparam int LOCK_POS    = 7;
  localparam int LVL_HI_POS  = 3;
  localparam int LVL_LO_POS  = 2;
  // Power-up values of the status fields
  localparam logic LOCK_RST  = 1'b0;
  localparam logic LVL_RST   = 1'b1;
  // Receive buffer depth on the host
  localparam int RX_DEPTH    = 2;
  // Host sequencer states, Gray along idle-start-low-high
  typedef enum logic [2:0] {
    SFP_IDLE  = 3'b000,
    SFP_START = 3'b001,
    SFP_LOW   = 3'b011,
    SFP_HIGH  = 3'b010,
    SFP_NEXT  = 3'b110,
    SFP_STOP  = 3'b100
  } sfp_state_t;
endpackage : sfp_pkg

// File: core/sfp_if.sv
// Link pins between the host end and the flash device end.
// Assumes the bench instantiates one per pair and joins both ends.
`timescale 1ns/1ps
interface sfp_if;
  logic sel_n;      // Select, active low
  logic sclk;       // Link clock, made by the host
  logic mosi;       // Host to device data
  logic miso;       // Device output value
  logic miso_oe_n;  // Device drives miso while low
  logic pause_n;    // Pause request, active low
  logic wprot_n;    // Write-protect pin, active low
  logic miso_line;  // Resolved wire level
  // Released wire shows the inverse, so a sample taken late is caught
  assign miso_line = miso_oe_n ? ~miso : miso;
  // Device end
  modport dev (
    input  sel_n, sclk, mosi, pause_n, wprot_n,
    output miso, miso_oe_n
  );
  // Host end
  modport host (
    output sel_n, sclk, mosi, pause_n, wprot_n,
    input  miso_line
  );
endinterface : sfp_if

// File: core/sfp_buf.sv
// Small ready/valid FIFO held in flip-flops.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sfp_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  // Filling side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // Draining side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Whole buffer state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // Storage
    logic [AW-1:0]           wp;   // Write index
    logic [AW-1:0]           rp;   // Read index
    logic [AW:0]             cnt;  // Entries held
  } sfp_buf_t;

  sfp_buf_t r;
  sfp_buf_t next_r;

  // Wrapping pointer step, shared by both pointers
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : step

  wire logic push = in_valid_i & in_ready_o;
  wire logic pop  = out_valid_o & out_ready_i;

  // Full and empty come straight from the count
  assign in_ready_o  = (r.cnt < (AW + 1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o  = r.mem[r.rp];

  // Next state: write, read, count
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data_i;
      next_r.wp        = step(r.wp);
    end
    if (pop) begin
      next_r.rp = step(r.rp);
    end
    // Simultaneous push and pop leave the count alone
    if (push && !pop) begin
      next_r.cnt = r.cnt + (AW + 1)'(1);
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - (AW + 1)'(1);
    end
  end

  // Register the state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : sfp_buf

// File: core/sfp_dev.sv
// Flash device end: serial shifter, pause, status protection.
// Assumes the link clock from the host and a power-up reset.
// Operation
// - Capture input bits on clock rise
// - Change output bit on clock fall
// - Select fall opens frame, stays low
// - Modes 0 and 3 both accepted
// - Host pauses only while selected
// - Pause entry takes effect in clock low
// - Pause exit takes effect in clock low
// - Paused: output released, inputs ignored
// - Select high while paused resets logic
// - Host resumes with pause high, select low
// - Refuse status write if locked, pin low
// - Pin high makes lock bit inert
// - Sector and block from address bytes
// - Most significant bit first
// - Early select rise aborts instruction
// - Lock bit clear after power-up
`timescale 1ns/1ps
module sfp_dev
  import sfp_pkg::*;
(
  // Link pins
  sfp_if.dev                           link,
  // Power-up reset, active high
  input  wire logic                    srst_i,
  // Read data handed out at each byte boundary
  input  wire logic [7:0]              tx_data_i,
  // Received byte stream
  output logic [7:0]                   rx_data_o,
  output logic                         rx_strobe_o,
  output logic [7:0]                   opcode_o,
  // Decoded address
  output logic                         addr_valid_o,
  output logic [ADDR_W-SECTOR_LSB-1:0] sector_o,
  output logic [ADDR_W-BLOCK_LSB-1:0]  block_o,
  // Status register and refusal flag
  output logic [7:0]                   status_o,
  output logic                         refused_o
);
  import sfp_pkg::*;

  // Frame state on the rising edge; cleared by deselect
  typedef struct packed {
    logic [2:0]        bits;   // Bits taken in this byte
    logic [6:0]        sh;     // Partial byte
    logic [2:0]        nbyte;  // Bytes done, saturating
    logic [7:0]        op;     // First byte of the frame
    logic [ADDR_W-1:0] addr;   // Address bytes
    logic              aok;    // Address complete
    logic [7:0]        rx;     // Last whole byte
    logic              stb;    // Byte completed here
    logic              held;   // Pause seen at this rise
  } sfp_lnk_t;

  // Output state on the falling edge; cleared by deselect
  typedef struct packed {
    logic [7:0] sh;     // Outgoing shift
    logic       drive;  // Output enabled
  } sfp_out_t;

  // Status state; survives deselect, reset at power-up
  typedef struct packed {
    logic lock;  // Lock bit
    logic hi;    // Protection level high bit
    logic lo;    // Protection level low bit
    logic ref_;  // Last status write refused
    logic wp1;   // Protect pin first stage
    logic wp2;   // Protect pin second stage
  } sfp_sts_t;

  sfp_lnk_t l;
  sfp_lnk_t next_l;
  sfp_out_t o;
  sfp_out_t next_o;
  sfp_sts_t s;
  sfp_sts_t next_s;

  // Deselect clears the serial logic without needing a clock edge
  wire logic rst_link = srst_i | link.sel_n;

  // The byte that completes on this rising edge
  wire logic [7:0] byte_in = {l.sh, link.mosi};

  // Pause level sampled at this rise (pin only moves in clock low)
  wire logic pause_now = ~link.pause_n;

  // A byte ends on the eighth accepted rising edge
  wire logic byte_end = ~pause_now & (l.bits == 3'd7);

  // Status write may proceed
  // locked and pin low refuses
  wire logic wr_ok = s.wp2 | ~s.lock;

  // Rising-edge logic: shift in, count, decode
  always_comb begin
    next_l      = l;
    next_l.stb  = 1'b0;
    // pause in clock low holds this edge
    next_l.held = pause_now;
    // clock and data ignored while paused
    if (!pause_now) begin
      // take the bit on the rise
      // bits enter at the bottom, top first
      next_l.sh   = {l.sh[5:0], link.mosi};
      next_l.bits = l.bits + 3'd1;
      if (byte_end) begin
        next_l.rx  = byte_in;
        next_l.stb = 1'b1;
        if (l.nbyte != 3'd7) begin
          next_l.nbyte = l.nbyte + 3'd1;
        end
        if (l.nbyte == 3'd0) begin
          next_l.op = byte_in;
        end
        // three address bytes after the opcode
        if (l.nbyte != 3'd0 && l.nbyte <= 3'(ADDR_BYTES)) begin
          next_l.addr = {l.addr[ADDR_W-9:0], byte_in};
          next_l.aok  = (l.nbyte == 3'(ADDR_BYTES));
        end
      end
    end
  end

  // frame starts clean after select fall
  // select high in pause clears it all
  // partial instruction dropped on select rise
  always_ff @(posedge link.sclk or posedge rst_link) begin
    if (rst_link) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Falling-edge logic: load or shift the outgoing byte
  always_comb begin
    next_o = o;
    // edges wait until the pause is released
    if (link.pause_n) begin
      if (l.bits == 3'd0 && l.nbyte != 3'd0) begin
        // Byte boundary: fresh data, output turned on
        next_o.sh    = tx_data_i;
        next_o.drive = 1'b1;
      end else begin
        next_o.sh = {o.sh[6:0], 1'b0};
      end
    end
  end

  // output changes only on the fall
  // mode 3 lead-in fall finds no byte yet
  always_ff @(negedge link.sclk or posedge rst_link) begin
    if (rst_link) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  // Status update; write lands when its data byte is whole
  always_comb begin
    next_s     = s;
    next_s.wp1 = link.wprot_n;
    next_s.wp2 = s.wp1;
    if (byte_end && l.nbyte == 3'd1 && l.op == STATUS_WRITE_CMD) begin
      if (wr_ok) begin
        next_s.lock = byte_in[LOCK_POS];
        next_s.hi   = byte_in[LVL_HI_POS];
        next_s.lo   = byte_in[LVL_LO_POS];
        next_s.ref_ = 1'b0;
      end else begin
        next_s.ref_ = 1'b1;
      end
    end
    // Edges outside a frame leave the status untouched
    if (link.sel_n) begin
      next_s = s;
    end
  end

  // Status is gated by select so frames outside it cannot write
  always_ff @(posedge link.sclk or posedge srst_i) begin
    if (srst_i) begin
      // lock clear, levels set at power-up
      s.lock <= LOCK_RST;
      s.hi   <= LVL_RST;
      s.lo   <= LVL_RST;
      s.ref_ <= 1'b0;
      s.wp1  <= 1'b1;
      s.wp2  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Paused state: in clock high the level seen at the last rise
  // stands, in clock low the pin acts at once
  wire logic paused = link.sclk ? l.held : ~link.pause_n;

  assign link.miso      = o.sh[7];
  assign link.miso_oe_n = ~o.drive | paused | link.sel_n;

  // User-side view of the frame
  assign rx_data_o    = l.rx;
  assign rx_strobe_o  = l.stb;
  assign opcode_o     = l.op;
  assign addr_valid_o = l.aok;
  assign sector_o     = l.addr[ADDR_W-1:SECTOR_LSB];
  assign block_o      = l.addr[ADDR_W-1:BLOCK_LSB];

  // Status byte: unused bits read zero
  always_comb begin
    status_o             = 8'h00;
    status_o[LOCK_POS]   = s.lock;
    status_o[LVL_HI_POS] = s.hi;
    status_o[LVL_LO_POS] = s.lo;
  end
  assign refused_o = s.ref_;
endmodule : sfp_dev

// File: tb/sfp_link_checker.sv
// Concurrent checks on the link pins of the mode 0 pair.
// Assumes pins sampled on the host clock, which also makes sclk.
`timescale 1ns/1ps
module sfp_link_checker #(
  parameter int HALF  = 2,     // Host cycles per half period
  parameter bit MODE3 = 1'b0   // Idle clock level
) (
  // Host clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Link signals
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic pause_n
);
  logic [7:0] hi_cnt;  // Samples the clock has been high
  // Count the high phase; cleared while low
  always_ff @(posedge clock_i) begin
    if (srst_i || !sclk) hi_cnt <= 8'h00;
    else hi_cnt <= hi_cnt + 8'h01;
  end
  // All checks ride on the host clock, which makes every link edge
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  mosi_rise_stable_a: assert property (
    $rose(sclk) |-> $stable(mosi)) else $error("mosi moved at rise");
  miso_fall_only_a: assert property (
    !sel_n && $stable(sel_n) && $changed(miso) |-> $fell(sclk))
    else $error("miso moved off a fall");
  clock_in_frame_a: assert property (
    $changed(sclk) |-> !sel_n) else $error("sclk moved while idle");
  idle_level_a: assert property (
    sel_n |-> sclk == MODE3) else $error("wrong idle clock level");
  high_phase_len_a: assert property (
    $fell(sclk) |-> hi_cnt == HALF) else $error("high phase length");
  pause_selected_a: assert property (
    !pause_n |-> !sel_n) else $error("pause while deselected");
  pause_clock_low_a: assert property (
    $changed(pause_n) |-> !sclk) else $error("pause moved in high");
  pause_release_a: assert property (
    !sel_n && !pause_n && !sclk |-> miso_oe_n)
    else $error("miso driven while paused");
  deselect_release_a: assert property (
    sel_n |-> miso_oe_n) else $error("miso driven while deselected");
endmodule : sfp_link_checker

// File: tb/tb.sv
// Bench: both ends joined, one pair per clock mode.
// Assumes the design files compile first; the host makes sclk.
`timescale 1ns/1ps
module tb;
  import sfp_pkg::*;
  localparam int LIMIT = 20000;       // Cycle ceiling
  logic       clock_i;                // Host clock
  logic       srst_i;                 // Host reset
  logic       dev_rst;                // Device power-up reset
  logic [1:0] wp, tx_valid, tx_last;  // Per pair stimulus
  logic [1:0] rdy, tx_ready, rx_valid, busy, av, refused, dstb;
  logic [7:0] tx_data [2];
  logic [7:0] dtx [2];                // Device read data
  logic [7:0] rx_data [2];
  logic [7:0] dev_rx [2];
  logic [7:0] opcode [2];
  logic [7:0] status [2];
  logic [ADDR_W-SECTOR_LSB-1:0] sector [2];
  logic [ADDR_W-BLOCK_LSB-1:0]  block [2];
  logic [8:0] expq [2][$];            // Check flag and expected rx byte
  logic [8:0] e;
  logic [7:0] wire_sh;                // Bits seen on mosi, mode 0 pair
  // Device views as they last stood with select low
  logic [7:0] cap_op [2];
  logic [7:0] cap_rx [2];
  logic [1:0] cap_av;
  logic [1:0] cap_stb = 2'b00;        // Byte strobe ever seen
  logic [ADDR_W-SECTOR_LSB-1:0] cap_sec [2];
  logic [ADDR_W-BLOCK_LSB-1:0]  cap_blk [2];
  int         mismatches, samples_checked, cycles;
  sfp_if lnk [2] ();
  // Pair 0 idles low, pair 1 idles high
  for (genvar g = 0; g < 2; g++) begin : gp
    sfp_host #(.HALF(2), .MODE3(g == 1)) u_sfp_host (
      .clock_i(clock_i), .srst_i(srst_i), .link(lnk[g]),
      .wprot_n_i(wp[g]), .tx_data_i(tx_data[g]),
      .tx_valid_i(tx_valid[g]), .tx_last_i(tx_last[g]),
      .tx_ready_o(tx_ready[g]), .rx_data_o(rx_data[g]),
      .rx_valid_o(rx_valid[g]), .rx_ready_i(rdy[g]), .busy_o(busy[g]));
    sfp_dev u_sfp_dev (
      .link(lnk[g]), .srst_i(dev_rst), .tx_data_i(dtx[g]),
      .rx_data_o(dev_rx[g]), .rx_strobe_o(dstb[g]),
      .opcode_o(opcode[g]), .addr_valid_o(av[g]),
      .sector_o(sector[g]), .block_o(block[g]),
      .status_o(status[g]), .refused_o(refused[g]));
  end
  sfp_link_checker #(.HALF(2), .MODE3(1'b0)) u_sfp_link_checker (
    .clock_i(clock_i), .srst_i(srst_i), .sel_n(lnk[0].sel_n),
    .sclk(lnk[0].sclk), .mosi(lnk[0].mosi), .miso(lnk[0].miso),
    .miso_oe_n(lnk[0].miso_oe_n), .pause_n(lnk[0].pause_n));
  // Free-running host clock, 25 ns
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // Watchdog: a hang ends the run as a failure
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      summarize();
    end
  end
  // Shift in mosi at each active rise, as the device sees it
  always @(posedge lnk[0].sclk) begin
    if (lnk[0].sel_n === 1'b0 && lnk[0].pause_n === 1'b1)
      wire_sh <= {wire_sh[6:0], lnk[0].mosi};
  end
  // Deselect clears the device's frame view, so keep its last selected
  // value; busy is still the pre-edge level when select rises
  always @(posedge clock_i) begin
    for (int p = 0; p < 2; p++) begin
      if (busy[p] === 1'b1) begin
        cap_op[p]  <= opcode[p];
        cap_rx[p]  <= dev_rx[p];
        cap_av[p]  <= av[p];
        cap_sec[p] <= sector[p];
        cap_blk[p] <= block[p];
        if (dstb[p] === 1'b1) cap_stb[p] <= 1'b1;
      end
    end
  end
  // Drain rx streams; opcode slots float, so only later bytes compare
  always @(posedge clock_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rx_valid[p] === 1'b1 && rdy[p] === 1'b1 && expq[p].size() > 0)
      begin
        e = expq[p].pop_front();
        if (e[8]) check("rx_data", rx_data[p], e[7:0]);
      end
    end
  end
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // One byte on the tx stream, held until taken
  task automatic send(input int p, input logic [7:0] d, input logic l);
    int n;
    @(posedge clock_i);
    #1;
    tx_data[p] = d;
    tx_last[p] = l;
    tx_valid[p] = 1'b1;
    n = 0;
    while (tx_ready[p] !== 1'b1 && n < 500) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    // A byte never taken counts against the run
    if (n == 500) mismatches++;
    @(posedge clock_i);
    #1;
    tx_valid[p] = 1'b0;
  endtask : send
  // Wait for select to rise again, bounded
  task automatic wait_idle(input int p);
    int n;
    n = 0;
    repeat (4) @(posedge clock_i);
    while (busy[p] !== 1'b0 && n < 500) begin
      @(posedge clock_i);
      n++;
    end
    // A frame that never closes counts against the run
    if (n == 500) mismatches++;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : wait_idle
  // Whole frame; bytes after the opcode return the device's read data
  task automatic frame(input int p, input logic [7:0] b [$]);
    foreach (b[i]) begin
      expq[p].push_back({i > 0, dtx[p]});
      send(p, b[i], i == b.size() - 1);
    end
    wait_idle(p);
    if (p == 0) check("mosi_bits", wire_sh, b[b.size() - 1]);
  endtask : frame
  // Host reset forces select high wherever the frame stands
  task automatic host_reset();
    @(posedge clock_i);
    #1;
    srst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    srst_i = 1'b0;
    expq[0].delete();
  endtask : host_reset
  // Main sequence
  initial begin
    srst_i = 1'b1;
    dev_rst = 1'b1;
    wp = 2'b11;
    tx_valid = 2'b00;
    tx_last = 2'b00;
    rdy = 2'b11;
    tx_data = '{8'h00, 8'h00};
    dtx = '{8'h96, 8'h69};
    repeat (4) @(posedge clock_i);
    #1;
    srst_i = 1'b0;
    dev_rst = 1'b0;
    check("status", status[0], 8'h0C);
    check("refused", refused[0], 1'b0);
    frame(0, '{STATUS_WRITE_CMD, 8'hFF});
    check("opcode", cap_op[0], STATUS_WRITE_CMD);
    check("dev_rx", cap_rx[0], 8'hFF);
    check("rx_strobe", cap_stb[0], 1'b1);
    check("status", status[0], 8'h8C);
    // Locked and pin low: write refused
    wp[0] = 1'b0;
    frame(0, '{STATUS_WRITE_CMD, 8'h00});
    check("status", status[0], 8'h8C);
    check("refused", refused[0], 1'b1);
    // Pin high makes the lock inert
    wp[0] = 1'b1;
    frame(0, '{STATUS_WRITE_CMD, 8'h00});
    check("status", status[0], 8'h00);
    check("refused", refused[0], 1'b0);
    wp[0] = 1'b0;
    frame(0, '{STATUS_WRITE_CMD, 8'h04});
    check("status", status[0], 8'h04);
    // Select rises in mid data byte
    send(0, STATUS_WRITE_CMD, 1'b0);
    send(0, 8'h00, 1'b0);
    repeat (20) @(posedge clock_i);
    host_reset();
    check("status", status[0], 8'h04);
    // Select rises while paused between bytes
    send(0, STATUS_WRITE_CMD, 1'b0);
    repeat (40) @(posedge clock_i);
    #1;
    check("pause_n", lnk[0].pause_n, 1'b0);
    host_reset();
    check("opcode", opcode[0], 8'h00);
    // Receiver stalls; host pauses mid frame and resumes
    rdy[0] = 1'b0;
    fork
      frame(0, '{8'h20, 8'hA5, 8'hC3, 8'h7E});
      begin
        repeat (150) @(posedge clock_i);
        #1;
        check("pause_n", lnk[0].pause_n, 1'b0);
        rdy[0] = 1'b1;
      end
    join
    check("opcode", cap_op[0], 8'h20);
    check("status", status[0], 8'h04);
    check("addr_valid", cap_av[0], 1'b1);
    check("sector", cap_sec[0], 12'hA5C);
    check("block", cap_blk[0], 9'h14B);
    // Idle-high clock pair
    frame(1, '{STATUS_WRITE_CMD, 8'h08});
    check("status", status[1], 8'h08);
    frame(1, '{8'h20, 8'h12, 8'h34, 8'h56});
    check("opcode", cap_op[1], 8'h20);
    check("addr_valid", cap_av[1], 1'b1);
    check("rx_strobe", cap_stb[1], 1'b1);
    check("refused", refused[1], 1'b0);
    check("sector", cap_sec[1], 12'h123);
    check("block", cap_blk[1], 9'h024);
    repeat (10) @(posedge clock_i);
    summarize();
  end
endmodule : tb
